// ==== inc/scp_pkg.sv ====
package scp_pkg;

  // register bus shape
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFF_TRIM = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_DIVCTRL = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_TIMERSTAT = 2'h2;

  // clock_divide_control fields
  localparam int CHG_EN_BIT = 7;
  localparam int SEL_W = 4;
  localparam logic [DATA_W-1:0] UNLOCK_PATTERN = 8'h80;
  localparam logic [SEL_W-1:0] SEL_RST_PLAIN = 4'h0;
  localparam logic [SEL_W-1:0] SEL_RST_DIV8 = 4'h3;
  localparam logic [SEL_W-1:0] SEL_MAX_CODE = 4'h8;

  // async_timer_status_reg fields
  localparam int EXTCLK_BIT = 6;

  // oscillator_trim fields
  localparam int TRIM_RANGE_BIT = 7;
  localparam int TRIM_FINE_W = 7;

  // timing: unlock window in divided cpu cycles, strap settling in source clock cycles
  localparam int UNLOCK_WINDOW_CYCLES = 4;
  localparam logic [2:0] UNLOCK_WINDOW_LOAD = 3'(UNLOCK_WINDOW_CYCLES);
  localparam logic [2:0] UNLOCK_WINDOW_LAST = 3'h1;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'(SYNC_STAGES);

  // prescaler counter width: enough for a factor of 256
  localparam int CNT_W = 8;

  // one register access from software
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } scp_bus_req_t;

  // oscillator trim as seen by the RC oscillator
  typedef struct packed {
    logic rangeHigh;
    logic [TRIM_FINE_W-1:0] fine;
  } scp_trim_t;

endpackage : scp_pkg

// ==== hdl/scp_sync.sv ====
// two-stage level synchroniser; first stage feeds only the second
module scp_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut_r
);

  logic [W-1:0] meta_r;

  // both stages freeze with the clock enable like all other state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      syncOut_r <= '0;
    end else if (clkEn) begin
      meta_r <= asyncIn;
      syncOut_r <= meta_r;
    end
  end

endmodule : scp_sync

// ==== hdl/scp_divider.sv ====
// power-of-two prescaler running at the undivided source rate
module scp_divider #(
  parameter int CNT_W = scp_pkg::CNT_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [scp_pkg::SEL_W-1:0] selCode,
  output logic sysTick,
  output logic divClk_r,
  output logic [scp_pkg::SEL_W-1:0] activeCode_r
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] half;
  logic [scp_pkg::SEL_W-1:0] clampCode;

  // reserved codes saturate at the largest factor
  assign clampCode = (activeCode_r > scp_pkg::SEL_MAX_CODE) ? scp_pkg::SEL_MAX_CODE
                                                             : activeCode_r;
  assign limit = CNT_W'((({1'b0, {CNT_W{1'b0}}} | (CNT_W+1)'(1)) << clampCode) - (CNT_W+1)'(1));
  assign half = CNT_W'(limit >> 1) + CNT_W'(1);

  // one tick per divided period; this is the cpu/io/flash clock enable
  assign sysTick = clkEn && (cnt_r == limit);
  assign cnt_nxt = sysTick ? '0 : CNT_W'(cnt_r + CNT_W'(1));

  // a synchronous counter stands in for the ripple chain: same count, no skew hazards
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (clkEn) begin
      cnt_r <= cnt_nxt;
    end
  end

  // new factor only taken at a period boundary, so no runt pulse can appear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeCode_r <= scp_pkg::SEL_RST_PLAIN;
    end else if (sysTick) begin
      activeCode_r <= selCode;
    end
  end

  // divided clock level: high in the first half of each period
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divClk_r <= 1'b0;
    end else if (clkEn) begin
      if (limit == '0) begin
        divClk_r <= ~divClk_r; // factor 1 is shown at half rate on the level
      end else begin
        divClk_r <= (cnt_nxt < half);
      end
    end
  end

  property p_code_at_boundary;
    @(posedge sys_clk) disable iff (!reset_n)
    (activeCode_r != $past(activeCode_r)) |-> $past(sysTick);
  endproperty
  a_code_at_boundary: assert property (p_code_at_boundary)
    else $error("prescaler factor changed inside a period");

  property p_div1_every_cycle;
    @(posedge sys_clk) disable iff (!reset_n)
    (clkEn && activeCode_r == scp_pkg::SEL_RST_PLAIN) |-> sysTick;
  endproperty
  a_div1_every_cycle: assert property (p_div1_every_cycle)
    else $error("factor 1 did not tick every cycle");

  property p_div2_spacing;
    @(posedge sys_clk) disable iff (!reset_n)
    (sysTick && activeCode_r == 4'h1 && selCode == 4'h1)
      |=> (!sysTick and (clkEn |=> (clkEn |-> sysTick)));
  endproperty
  a_div2_spacing: assert property (p_div2_spacing)
    else $error("factor 2 tick spacing wrong");

endmodule : scp_divider

// ==== hdl/scp_ctrl.sv ====
// Functional notes
// - clock-out fuse drives system clock, even in reset
// - clock-out carries divided clock, any source
// - prescaler divides cpu, io, flash clocks
// - factor changes without glitches or faster periods
// - prescaler counts at source rate, unreadable
// - new factor active after two edges; here taken at the next period boundary
// - change-enable updates only with other bits zero
// - change-enable clears after four or setting write
// - reset loads select from divide-by-eight fuse
// - any select value accepted when unlocked
// - codes 0..8 give factors 1..256
// - reset loads factory trim, software may overwrite
// - trim bit 7 picks low or high range
// - trim bits 6..0 tune within range
module scp_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic chipReset_n,
  input wire scp_pkg::scp_bus_req_t busReq,
  output logic [scp_pkg::DATA_W-1:0] rdData_r,
  input wire logic clockOutputFuse,
  input wire logic divideByEightFuse,
  input wire logic [scp_pkg::DATA_W-1:0] factoryTrim,
  input wire logic portPinOut,
  input wire logic portPinOe,
  output logic clockOutPin_r,
  output logic clockOutPinOe_r,
  output logic sysTick,
  output logic sysClk_r,
  output scp_pkg::scp_trim_t oscTrim,
  output logic timerExtClockSelect
);

  localparam int STRAP_W = scp_pkg::DATA_W + 2;

  logic [STRAP_W-1:0] strapSync;
  logic fuseClkOutSync;
  logic fuseDiv8Sync;
  logic [scp_pkg::DATA_W-1:0] factoryTrimSync;
  logic [1:0] settleCnt_r;
  logic strapDone_r;
  logic loadStraps;
  logic [scp_pkg::DATA_W-1:0] trim_r;
  logic [scp_pkg::SEL_W-1:0] divSel_r;
  logic [scp_pkg::SEL_W-1:0] activeCode;
  logic changeEn_r;
  logic [2:0] window_r;
  logic extClk_r;
  logic wrDiv;
  logic unlockWr;
  logic selWr;
  logic divClk;

  // fuse levels and the factory trim byte come from outside the clock domain
  scp_sync #(
    .W(STRAP_W)
  ) u_strap_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .asyncIn({clockOutputFuse, divideByEightFuse, factoryTrim}),
    .syncOut_r(strapSync)
  );

  assign fuseClkOutSync = strapSync[STRAP_W-1];
  assign fuseDiv8Sync = strapSync[STRAP_W-2];
  assign factoryTrimSync = strapSync[scp_pkg::DATA_W-1:0];

  // straps are caught once the synchroniser has settled after power-on
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      settleCnt_r <= '0;
      strapDone_r <= 1'b0;
    end else if (clkEn) begin
      if (settleCnt_r != scp_pkg::STRAP_SETTLE) begin
        settleCnt_r <= 2'(settleCnt_r + 2'h1);
      end else begin
        strapDone_r <= 1'b1;
      end
    end
  end

  // chip reset or the settling phase reloads select and trim from the straps and clears change-enable and ext select
  assign loadStraps = !chipReset_n || !strapDone_r;

  // the prescaler itself keeps running through chip reset
  scp_divider #(
    .CNT_W(scp_pkg::CNT_W)
  ) u_divider (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .selCode(divSel_r),
    .sysTick(sysTick),
    .divClk_r(divClk),
    .activeCode_r(activeCode)
  );

  assign sysClk_r = divClk;

  // write decode for the protected control register
  assign wrDiv = busReq.wr && (busReq.addr == scp_pkg::OFF_DIVCTRL) && !loadStraps;
  assign unlockWr = wrDiv && (busReq.wdata == scp_pkg::UNLOCK_PATTERN);
  assign selWr = wrDiv && !busReq.wdata[scp_pkg::CHG_EN_BIT] && changeEn_r;

  // change-enable and its window; counted in divided cpu cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      changeEn_r <= 1'b0;
      window_r <= '0;
    end else if (clkEn) begin
      if (loadStraps) begin
        changeEn_r <= 1'b0;
        window_r <= '0;
      end else if (selWr) begin
        changeEn_r <= 1'b0;
        window_r <= '0;
      end else if (unlockWr && !changeEn_r) begin
        changeEn_r <= 1'b1;
        window_r <= scp_pkg::UNLOCK_WINDOW_LOAD;
      end else if (changeEn_r && sysTick) begin
        // a repeated unlock write lands here too: no restart, no clear
        if (window_r == scp_pkg::UNLOCK_WINDOW_LAST) begin
          changeEn_r <= 1'b0;
        end
        window_r <= 3'(window_r - 3'h1);
      end
    end
  end

  // division select: fuse value on reset, any code while unlocked
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divSel_r <= scp_pkg::SEL_RST_PLAIN;
    end else if (clkEn) begin
      if (loadStraps) begin
        divSel_r <= fuseDiv8Sync ? scp_pkg::SEL_RST_DIV8 : scp_pkg::SEL_RST_PLAIN;
      end else if (selWr) begin
        divSel_r <= busReq.wdata[scp_pkg::SEL_W-1:0];
      end
    end
  end

  // oscillator trim: factory byte on reset, free to rewrite afterwards
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_r <= '0;
    end else if (clkEn) begin
      if (loadStraps) begin
        trim_r <= factoryTrimSync;
      end else if (busReq.wr && busReq.addr == scp_pkg::OFF_TRIM) begin
        trim_r <= busReq.wdata;
      end
    end
  end

  // range bit and fine bits go straight to the oscillator; one driver for the whole struct
  assign oscTrim = '{rangeHigh: trim_r[scp_pkg::TRIM_RANGE_BIT],
                     fine: trim_r[scp_pkg::TRIM_FINE_W-1:0]};

  // timer oscillator input: crystal when clear, external clock when set
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      extClk_r <= 1'b0;
    end else if (clkEn) begin
      if (loadStraps) begin
        extClk_r <= 1'b0;
      end else if (busReq.wr && busReq.addr == scp_pkg::OFF_TIMERSTAT) begin
        extClk_r <= busReq.wdata[scp_pkg::EXTCLK_BIT];
      end
    end
  end

  assign timerExtClockSelect = extClk_r;

  // read data live for exactly one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_r <= '0;
    end else if (clkEn) begin
      rdData_r <= '0;
      if (busReq.rd) begin
        case (busReq.addr)
          scp_pkg::OFF_TRIM: rdData_r <= trim_r;
          scp_pkg::OFF_DIVCTRL: begin
            rdData_r[scp_pkg::CHG_EN_BIT] <= changeEn_r;
            rdData_r[scp_pkg::SEL_W-1:0] <= divSel_r;
          end
          scp_pkg::OFF_TIMERSTAT: rdData_r[scp_pkg::EXTCLK_BIT] <= extClk_r;
          default: rdData_r <= '0;
        endcase
      end
    end
  end

  // pin override: registered so the pin never sees a decode glitch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clockOutPin_r <= 1'b0;
      clockOutPinOe_r <= 1'b0;
    end else if (clkEn) begin
      if (fuseClkOutSync) begin
        clockOutPin_r <= divClk;
        clockOutPinOe_r <= 1'b1;
      end else begin
        clockOutPin_r <= portPinOut;
        clockOutPinOe_r <= portPinOe;
      end
    end
  end

  property p_unlock_cause;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(changeEn_r) |-> $past(unlockWr);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause)
    else $error("change-enable set without the unlock pattern");

  property p_window_end;
    @(posedge sys_clk) disable iff (!reset_n)
    (changeEn_r && window_r == scp_pkg::UNLOCK_WINDOW_LAST && sysTick && !loadStraps && !selWr)
      |=> !changeEn_r;
  endproperty
  a_window_end: assert property (p_window_end)
    else $error("change-enable outlived its window");

  property p_no_extend;
    @(posedge sys_clk) disable iff (!reset_n)
    (changeEn_r && unlockWr && !sysTick && clkEn && !loadStraps)
      |=> changeEn_r && window_r == $past(window_r);
  endproperty
  a_no_extend: assert property (p_no_extend)
    else $error("repeated unlock changed the window");

  property p_sel_cause;
    @(posedge sys_clk) disable iff (!reset_n)
    (divSel_r != $past(divSel_r)) |-> $past(selWr || loadStraps);
  endproperty
  a_sel_cause: assert property (p_sel_cause)
    else $error("divide select changed without unlock");

  property p_strap_load;
    @(posedge sys_clk) disable iff (!reset_n)
    (!chipReset_n && clkEn) |=>
      divSel_r == ($past(fuseDiv8Sync) ? scp_pkg::SEL_RST_DIV8 : scp_pkg::SEL_RST_PLAIN)
      && trim_r == $past(factoryTrimSync);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("reset did not load select or trim from straps");

  property p_clock_out;
    @(posedge sys_clk) disable iff (!reset_n)
    (fuseClkOutSync && clkEn) |=> clockOutPinOe_r && clockOutPin_r == $past(divClk);
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("clock-out pin not carrying divided clock");

  property p_unused_zero;
    @(posedge sys_clk) disable iff (!reset_n)
    (busReq.rd && busReq.addr == scp_pkg::OFF_DIVCTRL && clkEn) |=> rdData_r[6:4] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bits read nonzero");

endmodule : scp_ctrl

// ==== bench/scp_sw_model.sv ====
// software side of the register port: one access at a time, never interrupted
module scp_sw_model (
  input wire logic sys_clk,
  input wire logic [7:0] rdData,
  output scp_pkg::scp_bus_req_t busReq
);
  timeunit 1ns;
  timeprecision 1ps;

  initial busReq = '0;

  // strobe raised after an edge, dropped at the taking edge; read data caught mid-cycle after it
  task automatic access(input logic [1:0] a, input logic [7:0] d, input logic w,
                        output logic [7:0] q);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk);
    busReq.wr <= 1'h0;
    busReq.rd <= 1'h0;
    @(negedge sys_clk);
    q = rdData;
  endtask : access

  // trim is only changed while no nvm write runs
  task automatic writeReg(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(a, d, 1'h1, q);
  endtask : writeReg

  task automatic readReg(input logic [1:0] a, output logic [7:0] q);
    access(a, 8'h00, 1'h0, q);
  endtask : readReg

  // unlock then setting two edges later, nothing in between
  // caller picks a factor the part can run at ext select set before use
  task automatic setDivide(input logic [3:0] code, input logic [2:0] junk);
    writeReg(scp_pkg::OFF_DIVCTRL, scp_pkg::UNLOCK_PATTERN);
    writeReg(scp_pkg::OFF_DIVCTRL, {1'h0, junk, code});
  endtask : setDivide
endmodule : scp_sw_model

// ==== bench/test_system_clock_prescaler_control.sv ====
module test_system_clock_prescaler_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, reset_n, clkEn, chipReset_n, clockOutputFuse, divideByEightFuse;
  logic portPinOut, portPinOe, clockOutPin_r, clockOutPinOe_r, sysTick, sysClk_r;
  logic timerExtClockSelect;
  logic [7:0] factoryTrim, rdData_r, q;
  logic [3:0] code;
  scp_pkg::scp_bus_req_t busReq;
  scp_pkg::scp_trim_t oscTrim;
  logic [31:0] seed = 32'h09146AEC;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int n, old;

  scp_ctrl i_scp_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .chipReset_n(chipReset_n), .busReq(busReq), .rdData_r(rdData_r),
    .clockOutputFuse(clockOutputFuse), .divideByEightFuse(divideByEightFuse),
    .factoryTrim(factoryTrim), .portPinOut(portPinOut), .portPinOe(portPinOe),
    .clockOutPin_r(clockOutPin_r), .clockOutPinOe_r(clockOutPinOe_r), .sysTick(sysTick),
    .sysClk_r(sysClk_r), .oscTrim(oscTrim), .timerExtClockSelect(timerExtClockSelect));

  scp_sw_model i_scp_sw_model (.sys_clk(sys_clk), .rdData(rdData_r), .busReq(busReq));

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  // a hang is cut short well beyond the longest divide sweep
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // reserved codes run as the largest factor
  function automatic int factor(input logic [3:0] c);
    return (c > 4'h8) ? 256 : (1 << c);
  endfunction : factor

  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic expectReg(input logic [1:0] a, input logic [7:0] e, input string what);
    i_scp_sw_model.readReg(a, q);
    check(what, q, e);
  endtask : expectReg

  // cycles until the next enable pulse, sampled mid-cycle where it is settled
  task automatic tickGap(output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (sysTick !== 1'h1 && cnt < 600);
  endtask : tickGap

  // pin is one cycle behind its source, with random port traffic under it
  task automatic pinCheck(input int cnt);
    logic p, oe;
    repeat (cnt) begin
      @(posedge sys_clk);
      seed = lfsr(seed);
      portPinOut <= seed[0];
      portPinOe <= seed[1];
      @(negedge sys_clk);
      p = clockOutputFuse ? sysClk_r : portPinOut;
      oe = clockOutputFuse | portPinOe;
      @(negedge sys_clk);
      check("clock pin", clockOutPin_r, p);
      check("clock pin enable", clockOutPinOe_r, oe);
    end
  endtask : pinCheck

  task automatic powerReset();
    reset_n <= 1'h0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (5) @(posedge sys_clk);
  endtask : powerReset

  initial begin
    reset_n = 1'h0;
    clkEn = 1'h1;
    chipReset_n = 1'h1;
    clockOutputFuse = 1'h1;
    divideByEightFuse = 1'h1;
    factoryTrim = seed[7:0];
    portPinOut = 1'h0;
    portPinOe = 1'h0;
    powerReset();
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h03, "divide reset");
    expectReg(scp_pkg::OFF_TRIM, factoryTrim, "trim reset");
    check("trim out", {oscTrim.rangeHigh, oscTrim.fine}, factoryTrim);
    pinCheck(40);
    // locked register: stray values and bad unlock patterns change nothing
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h01);
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h81);
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h03, "locked divide");
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h80);
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h83, "unlock seen");
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h03);
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h03, "unlock cleared");
    // every factor, then one reserved code, junk in the unused bits
    old = 8;
    for (int c = 0; c < 10; c++) begin
      seed = lfsr(seed);
      code = (c == 9) ? {1'h1, seed[2:0] | 3'h1} : c[3:0];
      i_scp_sw_model.setDivide(code, seed[6:4]);
      tickGap(n);
      check("switch gap bound", n <= old + factor(code), 1'h1);
      tickGap(n);
      check("divided period", n, factor(code));
      expectReg(scp_pkg::OFF_DIVCTRL, {4'h0, code}, "divide select");
      old = factor(code);
    end
    // window of four at factor one; a rewrite must not restart it
    // wait out the reserved-code period so the window really counts at factor one
    i_scp_sw_model.setDivide(4'h0, 3'h0);
    tickGap(n);
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h80);
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h80);
    i_scp_sw_model.readReg(scp_pkg::OFF_DIVCTRL, q);
    check("window held", q, 8'h80);
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h00, "window expired");
    i_scp_sw_model.writeReg(scp_pkg::OFF_DIVCTRL, 8'h05);
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h00, "late setting");
    // chip reset keeps the clock pin running and reloads the straps
    @(posedge sys_clk);
    chipReset_n <= 1'h0;
    pinCheck(20);
    chipReset_n <= 1'h1;
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h03, "chip reset divide");
    seed = lfsr(seed);
    i_scp_sw_model.writeReg(scp_pkg::OFF_TRIM, seed[15:8]);
    expectReg(scp_pkg::OFF_TRIM, seed[15:8], "trim write");
    check("trim range", oscTrim.rangeHigh, seed[15]);
    check("trim fine", oscTrim.fine, seed[14:8]);
    i_scp_sw_model.writeReg(scp_pkg::OFF_TIMERSTAT, 8'h40);
    expectReg(scp_pkg::OFF_TIMERSTAT, 8'h40, "timer status");
    check("ext clock select", timerExtClockSelect, 1'h1);
    // enable low: no ticks and a still clock level
    @(posedge sys_clk);
    clkEn <= 1'h0;
    @(negedge sys_clk);
    q[0] = sysClk_r;
    repeat (12) begin
      @(negedge sys_clk);
      check("frozen tick", sysTick, 1'h0);
      check("frozen clock", sysClk_r, q[0]);
    end
    clkEn <= 1'h1;
    i_scp_sw_model.writeReg(2'h3, 8'hFF);
    expectReg(2'h3, 8'h00, "unmapped");
    // fuses unprogrammed: plain port pin and undivided start
    clockOutputFuse <= 1'h0;
    divideByEightFuse <= 1'h0;
    powerReset();
    expectReg(scp_pkg::OFF_DIVCTRL, 8'h00, "plain reset");
    pinCheck(40);
    conclude();
  end
endmodule : test_system_clock_prescaler_control
